//--- core/oges_pkg.sv
package oges_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_RISE_SEL   = 8'h00;
	localparam logic [7:0] OFS_SHUT_SEL   = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFS_SRC_LEVEL  = 8'h14;

	// field positions shared by both selection registers, except BIT_FOUR (rise selection only)
	localparam int BIT_PIN   = 0;
	localparam int BIT_CMP1  = 1;
	localparam int BIT_CMP2  = 2;
	localparam int BIT_CELL  = 3;
	localparam int BIT_FOUR  = 4;
	localparam int NUM_SRC   = 4;

	// status bits
	localparam int ST_RISE   = 0;
	localparam int ST_SHUT   = 1;
	localparam int ST_WIDTH  = 2;

	// reset values
	localparam logic [7:0] RISE_SEL_RST = 8'h00;
	localparam logic [7:0] SHUT_SEL_RST = 8'h00;
	localparam logic [1:0] IRQ_EN_RST   = 2'h0;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : oges_pkg

//--- core/oges_sync.sv
`timescale 1ns/1ps
module oges_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : oges_sync

//--- core/oges_top.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - rise enable 3 admits logic cell one
// - rise enable 2 admits comparator 2
// - rise enable 1 admits comparator 1
// - rise enable 0 admits routed pin
// - cleared rise enable fully blocks its source
// - shutdown enable 3: logic cell two low
// - shutdown enable 2: comparator 2 low
// - shutdown enable 1: comparator 1 low
// - shutdown enable 0: routed pin low
module oges_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        logic_cell_one,
	input  wire logic        logic_cell_two,
	input  wire logic        cmp1_out,
	input  wire logic        cmp2_out,
	input  wire logic        routed_pin,
	input  wire logic        src_four,
	output logic             rise_event,
	output logic             shutdown_req,
	output logic             irq
);
	import oges_pkg::*;

	logic [7:0]          rise_sel_q;
	logic [3:0]          shut_sel_q;
	logic [ST_WIDTH-1:0] status_q;
	logic [ST_WIDTH-1:0] irq_en_q;
	logic                rise_d;
	logic                shutdown_d;
	logic                rise_prev_q;
	logic                shut_prev_q;

	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_d;

	// pin-side inputs pass two flops first
	logic [5:0] raw_src;
	logic [5:0] src_s;
	assign raw_src = {src_four, logic_cell_one, logic_cell_two, cmp2_out, cmp1_out, routed_pin};

	oges_sync #(
		.WIDTH(6)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.async_in (raw_src),
		.sync_out (src_s)
	);

	wire pin_s   = src_s[0];
	wire cmp1_s  = src_s[1];
	wire cmp2_s  = src_s[2];
	wire cell2_s = src_s[3];
	wire cell1_s = src_s[4];
	wire four_s  = src_s[5];

	// rising-event qualification
	wire rise_pin  = rise_sel_q[BIT_PIN]  & pin_s;
	wire rise_cmp1 = rise_sel_q[BIT_CMP1] & cmp1_s;
	wire rise_cmp2 = rise_sel_q[BIT_CMP2] & cmp2_s;
	wire rise_cell = rise_sel_q[BIT_CELL] & cell1_s;
	// source 4 meaning unclear; treated like the others
	wire rise_four = rise_sel_q[BIT_FOUR] & four_s;

	// a cleared enable gates with and, so no glitch can leak through
	assign rise_d = rise_pin | rise_cmp1 | rise_cmp2 | rise_cell | rise_four;

	// shutdown: active when an enabled source is low
	wire shut_pin  = shut_sel_q[BIT_PIN]  & ~pin_s;
	wire shut_cmp1 = shut_sel_q[BIT_CMP1] & ~cmp1_s;
	wire shut_cmp2 = shut_sel_q[BIT_CMP2] & ~cmp2_s;
	wire shut_cell = shut_sel_q[BIT_CELL] & ~cell2_s;

	assign shutdown_d = shut_pin | shut_cmp1 | shut_cmp2 | shut_cell;

	// edge events for status
	wire rise_edge = rise_d & ~rise_prev_q;
	wire shut_edge = shutdown_d & ~shut_prev_q;
	wire [ST_WIDTH-1:0] ev_set = {shut_edge, rise_edge};

	// write path decode
	wire        wr_go     = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire [7:0]  wr_ofs    = awaddr_q[7:0];
	wire        wr_hi_ok  = (awaddr_q[31:8] == 24'h000000);
	wire        wr_rise   = wr_go & wr_hi_ok & (wr_ofs == OFS_RISE_SEL);
	wire        wr_shut   = wr_go & wr_hi_ok & (wr_ofs == OFS_SHUT_SEL);
	wire        wr_clr    = wr_go & wr_hi_ok & (wr_ofs == OFS_IRQ_CLEAR);
	wire        wr_en     = wr_go & wr_hi_ok & (wr_ofs == OFS_IRQ_ENABLE);
	wire        wr_stat   = wr_go & wr_hi_ok & (wr_ofs == OFS_STATUS);
	wire        wr_lvl    = wr_go & wr_hi_ok & (wr_ofs == OFS_SRC_LEVEL);
	wire        wr_mapped = wr_rise | wr_shut | wr_clr | wr_en | wr_stat | wr_lvl;
	wire        lane0     = wstrb_q[0];
	wire [ST_WIDTH-1:0] clr_mask = (wr_clr & lane0) ? wdata_q[ST_WIDTH-1:0] : '0;

	// ready only while ce runs, or a frozen slave would claim a transfer it never takes
	assign s_axi_awready = ~aw_have_q & ce;
	assign s_axi_wready  = ~w_have_q & ce;
	assign s_axi_arready = ~s_axi_rvalid & ce;
	assign irq           = |(status_q & irq_en_q);

	// read decode
	wire [7:0] rd_ofs   = s_axi_araddr[7:0];
	wire       rd_hi_ok = (s_axi_araddr[31:8] == 24'h000000);
	always_comb
	begin
		rdata_d = 32'h00000000;
		rresp_d = RESP_OKAY;
		if (!rd_hi_ok)
			rresp_d = RESP_SLVERR;
		else if (rd_ofs == OFS_RISE_SEL)
			rdata_d = {24'h000000, rise_sel_q};
		else if (rd_ofs == OFS_SHUT_SEL)
			rdata_d = {28'h0000000, shut_sel_q};
		else if (rd_ofs == OFS_STATUS)
			rdata_d = {30'h00000000, status_q};
		else if (rd_ofs == OFS_IRQ_CLEAR)
			rdata_d = 32'h00000000;
		else if (rd_ofs == OFS_IRQ_ENABLE)
			rdata_d = {30'h00000000, irq_en_q};
		else if (rd_ofs == OFS_SRC_LEVEL)
			rdata_d = {26'h0000000, src_s};
		else
			rresp_d = RESP_SLVERR;
	end

	// address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 32'h00000000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && !aw_have_q)
			begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid && !w_have_q)
			begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			else if (wr_go)
				w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && !s_axi_rvalid)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdata_d;
				s_axi_rresp  <= rresp_d;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// configuration registers, byte lane 0 only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rise_sel_q <= RISE_SEL_RST;
			shut_sel_q <= SHUT_SEL_RST[3:0];
			irq_en_q   <= IRQ_EN_RST;
		end
		else if (ce)
		begin
			if (wr_rise && lane0)
				rise_sel_q <= {1'b0, wdata_q[6:0]};
			if (wr_shut && lane0)
				shut_sel_q <= wdata_q[NUM_SRC-1:0];
			if (wr_en && lane0)
				irq_en_q <= wdata_q[ST_WIDTH-1:0];
		end
	end

	// set wins over a same-cycle clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_q    <= '0;
			rise_prev_q <= 1'b0;
			shut_prev_q <= 1'b0;
			rise_event  <= 1'b0;
			shutdown_req <= 1'b0;
		end
		else if (ce)
		begin
			status_q     <= (status_q & ~clr_mask) | ev_set;
			rise_prev_q  <= rise_d;
			shut_prev_q  <= shutdown_d;
			rise_event   <= rise_d;
			shutdown_req <= shutdown_d;
		end
	end
endmodule : oges_top

//--- bench/oges_assertions.sv
`timescale 1ns/1ps
module oges_assertions (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic logic_cell_one,
	input logic logic_cell_two,
	input logic cmp1_out,
	input logic cmp2_out,
	input logic routed_pin,
	input logic src_four,
	input logic rise_event,
	input logic shutdown_req
);
	// two sync flops plus output flop: sources show three edges later
	wire rise_any = logic_cell_one | cmp1_out | cmp2_out | routed_pin | src_four;
	wire shut_all = logic_cell_two & cmp1_out & cmp2_out & routed_pin;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_rise_quiet: assert property (!rise_any [*4] |-> !rise_event)
		else $error("rise event with no source high");
	chk_rise_cause: assert property ($rose(rise_event) |-> $past(rise_any, 3))
		else $error("rise event without a high source");
	chk_shut_quiet: assert property (shut_all [*4] |-> !shutdown_req)
		else $error("shutdown with no source low");
	chk_shut_cause: assert property ($rose(shutdown_req) |-> !$past(shut_all, 3))
		else $error("shutdown without a low source");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next edge");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped early");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
endmodule : oges_assertions
bind oges_top oges_assertions chk (.*);

//--- bench/oges_src_model.sv
`timescale 1ns/1ps
module oges_src_model (
	input  logic [5:0] want,
	output logic       routed_pin,
	output logic       cmp1_out,
	output logic       cmp2_out,
	output logic       logic_cell_one,
	output logic       src_four,
	output logic       logic_cell_two
);
	// plain levels; the block must cope with them changing at any time
	assign {logic_cell_two, src_four, logic_cell_one, cmp2_out, cmp1_out, routed_pin} = want;
endmodule : oges_src_model

//--- bench/tb_output_generator_event_source_select.sv
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module tb_output_generator_event_source_select;
	import oges_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        logic_cell_one, logic_cell_two, cmp1_out, cmp2_out, routed_pin, src_four;
	logic        rise_event, shutdown_req, irq;
	logic [5:0]  want = 6'h00;
	int          err_count = 0;
	int          check_count = 0;
	oges_top dut (.*);
	oges_src_model src (.*);
	always #12.5 aclk = ~aclk;
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, r)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rresp, r)
		if (r === RESP_OKAY) `CHK(s_axi_rdata, e)
	endtask : rd
	// sources need three edges to reach the outputs; six leaves margin
	task automatic drive(input logic [5:0] w);
		@(posedge aclk);
		want <= w;
		repeat (6) @(posedge aclk);
	endtask : drive
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_RISE_SEL, 32'h0, RESP_OKAY);
		rd(OFS_SHUT_SEL, 32'h0, RESP_OKAY);
		wr(OFS_SHUT_SEL, 32'hFF, RESP_OKAY);
		rd(OFS_SHUT_SEL, 32'h0F, RESP_OKAY);
		rd(8'h18, 32'h0, RESP_SLVERR);
		wr(8'h18, 32'h1, RESP_SLVERR);
		wr(OFS_SHUT_SEL, 32'h0, RESP_OKAY);
		$display("test registers done");
		for (int k = 0; k < 5; k++)
		begin
			wr(OFS_RISE_SEL, 32'(1 << k), RESP_OKAY);
			drive(6'(1 << k));
			`CHK(rise_event, 1'b1)
			wr(OFS_RISE_SEL, 32'(5'h1F ^ (1 << k)), RESP_OKAY);
			drive(6'(1 << k));
			`CHK(rise_event, 1'b0)
		end
		wr(OFS_RISE_SEL, 32'h0, RESP_OKAY);
		$display("test rising done");
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_SHUT_SEL, 32'(1 << k), RESP_OKAY);
			drive(6'h3F ^ (k == 3 ? 6'h20 : 6'(1 << k)));
			`CHK(shutdown_req, 1'b1)
			wr(OFS_SHUT_SEL, 32'(4'hF ^ (1 << k)), RESP_OKAY);
			drive(6'h3F ^ (k == 3 ? 6'h20 : 6'(1 << k)));
			`CHK(shutdown_req, 1'b0)
		end
		wr(OFS_SHUT_SEL, 32'h0, RESP_OKAY);
		$display("test shutdown done");
		drive(6'h00);
		rd(OFS_STATUS, 32'h3, RESP_OKAY);
		wr(OFS_RISE_SEL, 32'h1, RESP_OKAY);
		wr(OFS_IRQ_CLEAR, 32'h3, RESP_OKAY);
		wr(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
		drive(6'h01);
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		rd(OFS_SRC_LEVEL, 32'h1, RESP_OKAY);
		`CHK(irq, 1'b0)
		wr(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
		`CHK(irq, 1'b1)
		wr(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		`CHK(irq, 1'b0)
		$display("test interrupt done");
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		test_done();
	end
endmodule : tb_output_generator_event_source_select
